// ==== bench/capture_source_model.sv ====
/*
 * far side of the capture timer: pins, event bus, alternate count clock.
 * assumes drive is called just after a rising edge of ref_clk_i.
 */
`timescale 1ns/1ps
`default_nettype none
module capture_source_model (
   // clock and control
   input  wire logic       ref_clk_i,
   input  wire logic       alt_run_i,
   // sources
   output var  logic [3:0] pin_o,
   output var  logic [3:0] bus_o,
   output var  logic       alt_o
);
   logic [2:0] div = 3'h0;
   initial begin
      pin_o = 4'h0;
      bus_o = 4'h0;
      alt_o = 1'b0;
   end
   // an eighth of ref clock, held low when stopped
   always @(posedge ref_clk_i) begin
      div <= alt_run_i ? div + 3'h1 : 3'h0;
      alt_o <= alt_run_i & div[2];
   end
   task automatic drive(input logic [3:0] pins, input logic [3:0] bus);
      pin_o <= pins;
      bus_o <= bus;
   endtask
endmodule
`default_nettype wire

// ==== bench/testbench.sv ====
/*
 * self-checking bench with a cycle model of counter, captures and irq.
 * assumes the hand-over latencies: bus events one cycle, pins three.
 */
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import capture_pkg::*;
   localparam int CYC_MAX = 1000;
   logic ref_clk_i = 1'b0;
   logic rst_n_i, sel, alt_run, alt, irq_o, irq_m;
   logic [3:0] src, pins, evb, hit, pin_hit, eb_prev, ev;
   counter_write_type wr;
   logic [31:0] cnt_o, cnt_m;
   logic [3:0][31:0] cap_o, cap_m, pend;
   logic [3:0][3:0] ph;
   logic [3:0] ah;
   int num_errors = 0, compares = 0, cyc = 0, e = 0;
   always #4 ref_clk_i = ~ref_clk_i;
   capture_source_model capture_source_model_i (.ref_clk_i(ref_clk_i), .alt_run_i(alt_run),
      .pin_o(pins), .bus_o(evb), .alt_o(alt));
   free_running_input_capture free_running_input_capture_i (.ref_clk_i(ref_clk_i),
      .rst_n_i(rst_n_i), .count_clock_select_i(sel), .capture_source_select_i(src),
      .alt_clock_bus_i(alt), .capture_pin_i(pins), .event_bus_i(evb), .counter_write_i(wr),
      .counter_o(cnt_o), .capture_value_o(cap_o), .capture_input_interrupt_o(irq_o));
   task automatic fail(input string msg);
      num_errors++;
      $display("[FAIL] %0t %s", $time, msg);
   endtask
   task automatic test_done();
      $display("errors %0d compares %0d", num_errors, compares);
      if (num_errors == 0 && compares > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   // model sees the same pre-edge inputs as the design
   always @(posedge ref_clk_i) begin
      cyc++;
      if (cyc > CYC_MAX) begin
         fail("timeout");
         test_done();
      end
      if (!rst_n_i) begin
         cnt_m = '0;
         cap_m = '0;
         irq_m = 1'b0;
         hit = '0;
         pin_hit = '0;
         ph = '0;
         ah = '0;
         eb_prev = '0;
         e = 0;
      end else begin
         // captures and irq land at the strobe's own edge, so apply before comparing
         for (int c = 0; c < 4; c++)
            if (hit[c]) cap_m[c] = pend[c];
         irq_m = |pin_hit;
         compares += 3;
         if (cnt_o !== cnt_m) fail("counter");
         if (cap_o !== cap_m) fail("capture");
         if (irq_o !== irq_m) fail("interrupt");
         ph = {ph[2:0], pins};
         ah = {ah[2:0], alt};
         ev = (evb & ~eb_prev & src) | (ph[2] & ~ph[3] & ~src);
         eb_prev = evb;
         hit = ev;
         pin_hit = ev & ~src;
         for (int c = 0; c < 4; c++)
            pend[c] = (wr.write || sel) ? cnt_m + 32'h1 : cnt_m;
         e++;
         if (wr.write)
            cnt_m = wr.data;
         else if (sel ? (ah[2] & ~ah[3]) : (e % 2 == 0))
            cnt_m++;
      end
   end
   // random sources on both inputs; unselected ones must be ignored
   task automatic run(input logic mode, input int n);
      for (int i = 0; i < n; i++) begin
         @(posedge ref_clk_i);
         src <= 4'($urandom);
         capture_source_model_i.drive(4'($urandom), 4'($urandom));
         wr.write <= !mode && ($urandom % 3 == 0);
         wr.data <= ($urandom % 2) ? 32'hffff_fffe : 32'($urandom);
         @(posedge ref_clk_i);
         wr.write <= 1'b0;
         @(posedge ref_clk_i);
         capture_source_model_i.drive(4'h0, 4'h0);
         repeat (2) @(posedge ref_clk_i);
      end
   endtask
   initial begin
      void'($urandom(37204));
      rst_n_i = 1'b0;
      sel = 1'b0;
      alt_run = 1'b0;
      src = 4'h0;
      wr = '0;
      repeat (4) @(posedge ref_clk_i);
      rst_n_i <= 1'b1;
      run(1'b0, 40);
      rst_n_i <= 1'b0;
      sel <= 1'b1;
      repeat (4) @(posedge ref_clk_i);
      rst_n_i <= 1'b1;
      alt_run <= 1'b1;
      run(1'b1, 40);
      test_done();
   end
endmodule
`default_nettype wire

// ==== logic/capture_pkg.sv ====
/*
 * constants and carrier types for the free-running input capture timer.
 * assumes one 125 MHz reference clock and a synchronous active-low reset.
 */
package capture_pkg;
   localparam int unsigned CNT_WIDTH     = 32;
   localparam int unsigned NUM_CHANNELS  = 4;
   localparam int unsigned SYNC_STAGES   = 2;
   localparam logic [31:0] COUNT_RESET   = 32'h0000_0000;
   localparam logic [31:0] COUNT_STEP    = 32'h0000_0001;
   localparam logic        CLK_SEL_HALF  = 1'b0;
   localparam logic        CLK_SEL_BUS   = 1'b1;
   localparam logic        SRC_SEL_PIN   = 1'b0;
   localparam logic        SRC_SEL_EVBUS = 1'b1;

   typedef struct packed {
      logic                 write;
      logic [CNT_WIDTH-1:0] data;
   } counter_write_type;
endpackage

// ==== logic/event_strobe.sv ====
/*
 * rising-edge strobe generator, one per bit, with optional input synchroniser.
 * assumes a single clock; STAGES of 0 for inputs already on this clock.
 */
`timescale 1ns/1ps
`default_nettype none
module event_strobe #(
   parameter int unsigned WIDTH  = 4,
   parameter int unsigned STAGES = 2
) (
   // clock and reset
   input  wire logic             ref_clk_i,
   input  wire logic             rst_n_i,
   // event levels in, strobes out
   input  wire logic [WIDTH-1:0] level_i,
   output var  logic [WIDTH-1:0] strobe_o
);
   logic [WIDTH-1:0] prev;
   logic [WIDTH-1:0] clean;

   genvar g;
   generate
      for (g = 0; g < WIDTH; g++) begin : g_bit
         if (STAGES > 0) begin : g_sync
            // first stage feeds only the second stage
            logic [STAGES-1:0] chain;
            always_ff @(posedge ref_clk_i) begin
               if (!rst_n_i) begin
                  chain <= '0;
               end else begin
                  chain <= {chain[STAGES-2:0], level_i[g]};
               end
            end
            assign clean[g] = chain[STAGES-1];
         end else begin : g_direct
            assign clean[g] = level_i[g];
         end
         always_ff @(posedge ref_clk_i) begin
            if (!rst_n_i) begin
               prev[g] <= 1'b0;
            end else begin
               prev[g] <= clean[g];
            end
         end
         assign strobe_o[g] = clean[g] & ~prev[g];
      end
   endgenerate
endmodule
`default_nettype wire

// ==== logic/free_running_input_capture.sv ====
/*
 * free-running 32-bit counter with four capture channels.
 * assumes pins and the alternate clock bus are asynchronous; event bus is on ref_clk.
 */
`timescale 1ns/1ps
`default_nettype none
module free_running_input_capture
   import capture_pkg::*;
#(
   parameter int unsigned CHANNELS = capture_pkg::NUM_CHANNELS
) (
   // clock and reset
   input  wire logic                                      ref_clk_i,
   input  wire logic                                      rst_n_i,
   // configuration
   input  wire logic                                      count_clock_select_i,
   input  wire logic [CHANNELS-1:0]                       capture_source_select_i,
   // count sources
   input  wire logic                                      alt_clock_bus_i,
   // capture sources
   input  wire logic [CHANNELS-1:0]                       capture_pin_i,
   input  wire logic [CHANNELS-1:0]                       event_bus_i,
   // software counter write
   input  wire capture_pkg::counter_write_type            counter_write_i,
   // results
   output var  logic [capture_pkg::CNT_WIDTH-1:0]         counter_o,
   output var  logic [CHANNELS-1:0][capture_pkg::CNT_WIDTH-1:0] capture_value_o,
   output var  logic                                      capture_input_interrupt_o
);
   import capture_pkg::*;

   logic [CHANNELS-1:0]                 pin_strobe;
   logic [CHANNELS-1:0]                 bus_strobe;
   logic [CHANNELS-1:0]                 chan_strobe;
   logic [0:0]                          alt_strobe;
   logic                                half_phase;
   logic                                next_half_phase;
   logic                                tick;
   logic [CNT_WIDTH-1:0]                count;
   logic [CNT_WIDTH-1:0]                next_count;
   logic [CNT_WIDTH-1:0]                capture_source;
   logic [CHANNELS-1:0][CNT_WIDTH-1:0]  capture;
   logic [CHANNELS-1:0][CNT_WIDTH-1:0]  next_capture;
   logic                                irq;
   logic                                next_irq;

   event_strobe #(.WIDTH(CHANNELS), .STAGES(SYNC_STAGES)) u_pin_strobe (
      .ref_clk_i (ref_clk_i),
      .rst_n_i   (rst_n_i),
      .level_i   (capture_pin_i),
      .strobe_o  (pin_strobe)
   );

   // event bus already runs on ref_clk_i, so no synchroniser stages
   event_strobe #(.WIDTH(CHANNELS), .STAGES(0)) u_bus_strobe (
      .ref_clk_i (ref_clk_i),
      .rst_n_i   (rst_n_i),
      .level_i   (event_bus_i),
      .strobe_o  (bus_strobe)
   );

   // alternate clock bus is asynchronous, so it is synchronised first
   event_strobe #(.WIDTH(1), .STAGES(SYNC_STAGES)) u_alt_strobe (
      .ref_clk_i (ref_clk_i),
      .rst_n_i   (rst_n_i),
      .level_i   (alt_clock_bus_i),
      .strobe_o  (alt_strobe)
   );

   assign chan_strobe = (capture_source_select_i & bus_strobe)
                      | (~capture_source_select_i & pin_strobe);

   assign tick = (count_clock_select_i == CLK_SEL_BUS) ? alt_strobe[0] : half_phase;

   // incremented value when leading or colliding with a write
   // exact counter value otherwise
   // one-count lead in bus mode is intended; software must allow for it
   assign capture_source = (counter_write_i.write || count_clock_select_i == CLK_SEL_BUS)
                         ? count + COUNT_STEP : count;

   always_comb begin
      next_half_phase = ~half_phase;
      next_count = count + (tick ? COUNT_STEP : COUNT_RESET);
      // a write wins the counter; software keeps writes to half clock mode
      if (counter_write_i.write) begin
         next_count = counter_write_i.data;
      end
      for (int c = 0; c < CHANNELS; c++) begin
         next_capture[c] = chan_strobe[c] ? capture_source : capture[c];
      end
      // pin captures only; wrap raises nothing
      next_irq = |(chan_strobe & ~capture_source_select_i);
   end

   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         half_phase <= 1'b0;
         count      <= COUNT_RESET;
         capture    <= '0;
         irq        <= 1'b0;
      end else begin
         half_phase <= next_half_phase;
         count      <= next_count;
         capture    <= next_capture;
         irq        <= next_irq;
      end
   end

   // read-only words, driven from flops only
   assign counter_o                 = count;
   assign capture_value_o           = capture;
   assign capture_input_interrupt_o = irq;

   // one clock domain; reset holds every check off
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (!rst_n_i);

   property p_free_run;
      (rst_n_i && !counter_write_i.write && count_clock_select_i == CLK_SEL_HALF) [*2]
         |=> count == $past(count, 2) + COUNT_STEP;
   endproperty
   a_free_run: assert property (p_free_run) else $error("counter did not advance");

   property p_exact_capture;
      chan_strobe[0] && !counter_write_i.write && count_clock_select_i == CLK_SEL_HALF
         |=> capture[0] == $past(count);
   endproperty
   a_exact_capture: assert property (p_exact_capture) else $error("capture not exact");

   property p_lead_capture;
      chan_strobe[1] && count_clock_select_i == CLK_SEL_BUS
         |=> capture[1] == $past(count) + COUNT_STEP;
   endproperty
   a_lead_capture: assert property (p_lead_capture) else $error("capture not leading");

   property p_collision;
      chan_strobe[2] && counter_write_i.write
         |=> capture[2] == $past(count) + COUNT_STEP && count == $past(counter_write_i.data);
   endproperty
   a_collision: assert property (p_collision) else $error("collision mishandled");

   property p_hold;
      !chan_strobe[3] |=> $stable(capture[3]);
   endproperty
   a_hold: assert property (p_hold) else $error("capture changed without event");

   property p_irq_pin;
      |(chan_strobe & ~capture_source_select_i) |=> capture_input_interrupt_o;
   endproperty
   a_irq_pin: assert property (p_irq_pin) else $error("missing pin interrupt");

   property p_no_irq;
      !(|(chan_strobe & ~capture_source_select_i)) |=> !capture_input_interrupt_o;
   endproperty
   a_no_irq: assert property (p_no_irq) else $error("spurious interrupt");

   property p_single_strobe;
      chan_strobe[0] |=> !chan_strobe[0];
   endproperty
   a_single_strobe: assert property (p_single_strobe) else $error("strobe too long");

   property p_bus_source;
      capture_source_select_i[1] == SRC_SEL_EVBUS && pin_strobe[1] && !bus_strobe[1]
         |=> $stable(capture[1]);
   endproperty
   a_bus_source: assert property (p_bus_source) else $error("pin used on bus channel");

   property p_start;
      $rose(rst_n_i) && count_clock_select_i == CLK_SEL_HALF && !counter_write_i.write
         ##1 count_clock_select_i == CLK_SEL_HALF && !counter_write_i.write
         |=> count == COUNT_RESET + COUNT_STEP;
   endproperty
   a_start: assert property (p_start) else $error("no count after reset");

   property p_bus_idle;
      count_clock_select_i == CLK_SEL_BUS && !alt_strobe[0] && !counter_write_i.write
         |=> $stable(count);
   endproperty
   a_bus_idle: assert property (p_bus_idle) else $error("counter moved idle");

   property p_bus_count;
      count_clock_select_i == CLK_SEL_BUS && alt_strobe[0] && !counter_write_i.write
         |=> count == $past(count) + COUNT_STEP;
   endproperty
   a_bus_count: assert property (p_bus_count) else $error("bus tick missed");

   property p_wrap_quiet;
      count == '1 && tick && !counter_write_i.write
         && !(|(chan_strobe & ~capture_source_select_i))
         |=> count == COUNT_RESET && !capture_input_interrupt_o;
   endproperty
   a_wrap_quiet: assert property (p_wrap_quiet) else $error("wrap misbehaved");

   property p_pin_source;
      capture_source_select_i[0] == SRC_SEL_PIN && bus_strobe[0] && !pin_strobe[0]
         |=> $stable(capture[0]);
   endproperty
   a_pin_source: assert property (p_pin_source) else $error("bus used on pin channel");

   property p_capture_latch;
      chan_strobe[3] && !counter_write_i.write && count_clock_select_i == CLK_SEL_HALF
         |=> capture[3] == $past(count);
   endproperty
   a_capture_latch: assert property (p_capture_latch) else $error("capture missed");

   property p_strobe_once;
      (pin_strobe | bus_strobe) != '0
         |=> ((pin_strobe & $past(pin_strobe)) | (bus_strobe & $past(bus_strobe))) == '0;
   endproperty
   a_strobe_once: assert property (p_strobe_once) else $error("double strobe");

   c_capture_half: cover property (chan_strobe[0] && count_clock_select_i == CLK_SEL_HALF);
   c_capture_bus:  cover property (chan_strobe[1] && count_clock_select_i == CLK_SEL_BUS);
   c_collision:    cover property (chan_strobe[2] && counter_write_i.write);
   c_irq:          cover property (capture_input_interrupt_o);
   c_wrap:         cover property (count == '1 && tick);
endmodule
`default_nettype wire
